// *** mps_pkg.sv ***
`default_nettype none
package mps_pkg;
    // clock and enable filter timing
    localparam int CLK_MHZ         = 10;
    localparam int EN_DEBOUNCE_NS  = 100;
    localparam int EN_DEBOUNCE_RAW = (EN_DEBOUNCE_NS * CLK_MHZ + 999) / 1000;
    localparam int EN_DEBOUNCE_CYC = (EN_DEBOUNCE_RAW < 1) ? 1 : EN_DEBOUNCE_RAW;

    // register byte addresses
    localparam logic [7:0] ADDR_CTRL      = 8'h00;
    localparam logic [7:0] ADDR_STATUS    = 8'h04;
    localparam logic [7:0] ADDR_CPU_STRAP = 8'h08;
    localparam logic [7:0] ADDR_GPU_STRAP = 8'h0c;
    localparam logic [7:0] ADDR_SLEW      = 8'h10;
    localparam logic [7:0] ADDR_PULSES    = 8'h14;

    // control bits and reset value
    localparam int         CTRL_SINGLE_BIT = 0;
    localparam int         CTRL_USR_EN_BIT = 1;
    localparam logic [1:0] CTRL_RESET      = 2'h2;

    // latched strap word layout
    localparam int SF_FREQ  = 0;
    localparam int SF_IMAX  = 3;
    localparam int SF_OCP   = 6;
    localparam int SF_MON   = 9;
    localparam int SF_TRANS = 12;
    localparam int SF_OSR_OFF = 15;
    localparam logic [15:0] STRAP_RESET = 16'h0000;

    // status word layout
    localparam int ST_F_STATE = 0;
    localparam int ST_F_NPH   = 2;
    localparam int ST_F_GPU   = 4;
    localparam int ST_F_OSR   = 5;

    localparam logic [15:0] TRIM_STEP  = 16'h0004;
    localparam int          SLEW_SHIFT = 3;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN  = 2'b01,
        ST_STOP = 2'b10
    } mps_state_type;

    // higher resistor level, higher frequency, shorter on-time
    function automatic logic [7:0] mps_ton_scale(input logic [2:0] lvl);
        return 8'hf0 - {1'b0, lvl, 4'h0};
    endfunction

    // on-time in cycles from output code, input code and frequency level
    function automatic logic [15:0] mps_ton_calc(input logic [7:0] vout,
                                                 input logic [7:0] vin,
                                                 input logic [2:0] lvl);
        logic [15:0] prod;
        prod = vout * mps_ton_scale(lvl);
        if (vin == 8'h00)
            return prod;
        return prod / {8'h00, vin};
    endfunction

    function automatic logic [7:0] mps_slew_fast(input logic [2:0] code);
        return 8'({5'h00, code} + 8'h01) << SLEW_SHIFT;
    endfunction
endpackage
`default_nettype wire

// *** mps_chan_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface mps_chan_if #(parameter int NPH = 3);
    logic                  run;
    logic                  act;
    logic                  trig;
    logic                  usr_allow;
    logic                  osr_block;
    logic [1:0]            nph;
    logic [15:0]           ton;
    logic [NPH-1:0][7:0]   iph;
    logic [NPH-1:0]        hs;
    logic [NPH-1:0]        ls;
    logic                  busy;
    logic                  launch;

    modport seq (input run, act, trig, usr_allow, osr_block, nph, ton, iph,
                 output hs, ls, busy, launch);
    modport ctl (output run, act, trig, usr_allow, osr_block, nph, ton, iph,
                 input hs, ls, busy, launch);
endinterface
`default_nettype wire

// *** mps_phase_seq.sv ***
`timescale 1ns/10ps
`default_nettype none
module mps_phase_seq
    import mps_pkg::*;
#(
    parameter int NPH = 3
)(
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    mps_chan_if.seq   ch
);
    localparam int PW = (NPH > 1) ? $clog2(NPH) : 1;

    logic [PW-1:0]         ptr_reg;
    logic [1:0]            pend_reg;
    logic [NPH-1:0][15:0]  cnt_reg;
    logic [NPH-1:0][15:0]  cnt_next;
    logic [NPH-1:0]        hs_reg;
    logic [NPH-1:0]        ls_reg;
    logic [PW-1:0]         sel;
    logic [9:0]            summed_current_feedback;
    logic [7:0]            iavg;
    logic [15:0]           ton_trim;
    logic                  launch;

    // rotating selection; single phase always takes phase one
    assign sel = (ch.nph <= 2'd1) ? '0 : ptr_reg;

    // pulse length trimmed toward phase average
    always_comb
    begin
        summed_current_feedback = 10'h000;
        for (int p = 0; p < NPH; p++)
            if (p < int'(ch.nph))
                summed_current_feedback = summed_current_feedback + {2'b00, ch.iph[p]};
        iavg = 8'(summed_current_feedback / ((ch.nph == 2'd0) ? 10'd1 : {8'h00, ch.nph}));
        ton_trim = (ch.ton == 16'h0000) ? 16'h0001 : ch.ton;
        if (ch.iph[sel] > iavg)
            ton_trim = (ton_trim > TRIM_STEP) ? ton_trim - TRIM_STEP : 16'h0001;
        else if (ch.iph[sel] < iavg)
            ton_trim = ton_trim + TRIM_STEP;
    end

    // one pulse per trigger, at most three pending; overlap only while undershoot mode allows
    assign launch = ch.run && (pend_reg != 2'd0 || ch.trig) && cnt_reg[sel] == 16'h0000
                    && (hs_reg == '0 || ch.usr_allow);

    always_comb
    begin
        for (int p = 0; p < NPH; p++)
        begin
            cnt_next[p] = cnt_reg[p];
            if (launch && int'(sel) == p)
                cnt_next[p] = ton_trim;
            else if (cnt_reg[p] != 16'h0000)
                cnt_next[p] = cnt_reg[p] - 16'h0001;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            ptr_reg <= '0;
        else if (!ch.run)
            ptr_reg <= '0;
        else if (launch && ch.nph > 2'd1)
            ptr_reg <= (32'(ptr_reg) + 1 >= 32'(ch.nph)) ? '0 : PW'(ptr_reg + 1'b1);
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            pend_reg <= 2'd0;
        else if (!ch.run)
            pend_reg <= 2'd0;
        else if (ch.trig && !launch && pend_reg != 2'd3)
            pend_reg <= pend_reg + 2'd1;
        else if (!ch.trig && launch)
            pend_reg <= pend_reg - 2'd1;
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt_reg <= '0;
            hs_reg  <= '0;
            ls_reg  <= '0;
        end
        else
        begin
            cnt_reg <= cnt_next;
            for (int p = 0; p < NPH; p++)
            begin
                hs_reg[p] <= cnt_next[p] != 16'h0000;
                ls_reg[p] <= ch.act && p < int'(ch.nph) && cnt_next[p] == 16'h0000
                             && !ch.osr_block;
            end
        end
    end

    assign ch.hs     = hs_reg;
    assign ch.ls     = ls_reg;
    assign ch.busy   = (hs_reg != '0) || (pend_reg != 2'd0);
    assign ch.launch = launch;

    a_ptr_reset:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !ch.run |=> ptr_reg == '0)
        else $error("rotation pointer not back at phase one");

    a_hs_exclusive:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
        launch && !ch.usr_allow |-> hs_reg == '0)
        else $error("overlapping high-side drive outside transient");

    a_one_pulse:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
        launch |=> $countones(hs_reg & ~$past(hs_reg)) == 1)
        else $error("trigger did not start exactly one pulse");

    a_single_route:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
        launch && ch.nph == 2'd1 |=> hs_reg[0])
        else $error("single phase pulse went elsewhere");

    a_rotate_order:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
        launch && ch.nph > 2'd1 && ch.run ##1 ch.run |->
        32'(ptr_reg) == ((32'($past(ptr_reg)) + 1 >= 32'($past(ch.nph))) ? 0
                         : 32'($past(ptr_reg)) + 1))
        else $error("rotation order broken");

    a_osr_ls_off:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ch.osr_block |=> ls_reg == '0)
        else $error("low-side drive on during overshoot");
endmodule
`default_nettype wire

// *** mps_sequencer.sv ***
// Function
// - on enable rise, latch every strap and keep it for the whole run
// - each comparator trip starts one on-pulse on one phase; trips beyond three pending are dropped
// - single phase mode sends every trip to the same phase
// - multiphase mode hands trips to active phases in fixed rotation
// - rotation gives 180 degrees for two phases, 120 for three
// - no two high-side drives on together except during transients
// - per-phase pulse length trimmed to equalize currents, no setup
// - on-time follows input and output voltage; off-time follows the loop
// - phase count and gpu state decoded from sense pin ties
// - eight strap levels, settings rising monotonically with resistance
// - separate cpu and gpu straps, one common slew selection
// - slow ramp rate is exactly a quarter of fast rate
// - overshoot drops all low-side drives, restored once it subsides
// - transient strap at the 200 mV level disables overshoot cut
// - earlier trips give sooner pulses; no trips withhold pulses
// - enable filtered for 100 ns; falling enable gives soft stop
`timescale 1ns/10ps
`default_nettype none
module mps_sequencer
    import mps_pkg::*;
(
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic         psel_i,
    input  wire logic         penable_i,
    input  wire logic         pwrite_i,
    input  wire logic [7:0]   paddr_i,
    input  wire logic [31:0]  pwdata_i,
    output logic [31:0]       prdata_o,
    output logic              pready_o,
    output logic              pslverr_o,
    input  wire logic         regulator_enable_in_i,
    input  wire logic [2:0]   cpu_freq_limit_strap_i,
    input  wire logic [2:0]   cpu_imax_info_i,
    input  wire logic [2:0]   cpu_overcurrent_strap_i,
    input  wire logic [2:0]   cpu_monitor_strap_i,
    input  wire logic [3:0]   cpu_transient_strap_i,
    input  wire logic [2:0]   gpu_freq_limit_strap_i,
    input  wire logic [2:0]   gpu_imax_info_i,
    input  wire logic [2:0]   gpu_overcurrent_strap_i,
    input  wire logic [2:0]   gpu_monitor_strap_i,
    input  wire logic [3:0]   gpu_transient_strap_i,
    input  wire logic [2:0]   slew_select_strap_i,
    input  wire logic [2:0]   cpu_sense_pos_high_i,
    input  wire logic [2:0]   cpu_sense_neg_low_i,
    input  wire logic         gpu_sense_pos_high_i,
    input  wire logic         gpu_sense_neg_low_i,
    input  wire logic [7:0]   vin_code_i,
    input  wire logic [7:0]   cpu_vout_code_i,
    input  wire logic [7:0]   gpu_vout_code_i,
    input  wire logic         cpu_comp_trip_i,
    input  wire logic         gpu_comp_trip_i,
    input  wire logic         cpu_usr_trip_i,
    input  wire logic         gpu_usr_trip_i,
    input  wire logic         cpu_osr_trip_i,
    input  wire logic         gpu_osr_trip_i,
    input  wire logic [23:0]  cpu_phase_current_i,
    input  wire logic [7:0]   gpu_phase_current_i,
    output logic [2:0]        cpu_high_drive_o,
    output logic [2:0]        cpu_low_drive_o,
    output logic              gpu_high_drive_o,
    output logic              gpu_low_drive_o,
    output logic [7:0]        fast_voltage_change_rate_o,
    output logic [7:0]        slow_voltage_change_rate_o,
    output logic [2:0]        cpu_ocp_level_o,
    output logic [2:0]        gpu_ocp_level_o,
    output logic              regulator_active_o
);
    mps_state_type state_reg;
    logic [7:0]    en_cnt_reg;
    logic          en_filt_reg;
    logic [15:0]   cpu_strap_reg;
    logic [15:0]   gpu_strap_reg;
    logic [15:0]   cpu_strap_in;
    logic [15:0]   gpu_strap_in;
    logic [2:0]    slew_reg;
    logic [1:0]    cpu_nph_reg;
    logic          gpu_on_reg;
    logic [1:0]    ctrl_reg;
    logic          cpu_comp_prev_reg;
    logic          gpu_comp_prev_reg;
    logic [15:0]   cpu_pulse_reg;
    logic [15:0]   gpu_pulse_reg;
    logic [31:0]   prdata_reg;
    logic [1:0]    cpu_nph_eff;
    logic          addr_ok;
    logic          apb_setup;
    logic          apb_write;
    logic [31:0]   rd_mux;

    mps_chan_if #(.NPH(3)) cpu_if ();
    mps_chan_if #(.NPH(1)) gpu_if ();

    assign cpu_strap_in = {cpu_transient_strap_i, cpu_monitor_strap_i,
                           cpu_overcurrent_strap_i, cpu_imax_info_i, cpu_freq_limit_strap_i};
    assign gpu_strap_in = {gpu_transient_strap_i, gpu_monitor_strap_i,
                           gpu_overcurrent_strap_i, gpu_imax_info_i, gpu_freq_limit_strap_i};

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            en_cnt_reg  <= 8'h00;
            en_filt_reg <= 1'b0;
        end
        else if (regulator_enable_in_i == en_filt_reg)
            en_cnt_reg <= 8'h00;
        else if (32'(en_cnt_reg) + 1 >= EN_DEBOUNCE_CYC)
        begin
            en_cnt_reg  <= 8'h00;
            en_filt_reg <= regulator_enable_in_i;
        end
        else
            en_cnt_reg <= en_cnt_reg + 8'h01;
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            state_reg <= ST_IDLE;
        else
        begin
            unique case (state_reg)
                ST_IDLE:
                    if (en_filt_reg)
                        state_reg <= ST_RUN;
                ST_RUN:
                    if (!en_filt_reg)
                        state_reg <= ST_STOP;
                ST_STOP:
                    if (!cpu_if.busy && !gpu_if.busy)
                        state_reg <= ST_IDLE;
                default:
                    state_reg <= ST_IDLE;
            endcase
        end
    end

    // strap capture only on the way into run
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cpu_strap_reg <= STRAP_RESET;
            gpu_strap_reg <= STRAP_RESET;
            slew_reg      <= 3'h0;
            cpu_nph_reg   <= 2'd0;
            gpu_on_reg    <= 1'b0;
        end
        else if (state_reg == ST_IDLE && en_filt_reg)
        begin
            cpu_strap_reg <= cpu_strap_in;
            gpu_strap_reg <= gpu_strap_in;
            slew_reg      <= slew_select_strap_i;
            // unused phase: positive tied high, negative grounded
            if (cpu_sense_pos_high_i[0] && cpu_sense_neg_low_i[0])
                cpu_nph_reg <= 2'd0;
            else if (cpu_sense_pos_high_i[1] && cpu_sense_neg_low_i[1])
                cpu_nph_reg <= 2'd1;
            else if (cpu_sense_pos_high_i[2] && cpu_sense_neg_low_i[2])
                cpu_nph_reg <= 2'd2;
            else
                cpu_nph_reg <= 2'd3;
            gpu_on_reg <= !(gpu_sense_pos_high_i && gpu_sense_neg_low_i);
        end
    end

    // comparator trip edge becomes a switching trigger
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cpu_comp_prev_reg <= 1'b0;
            gpu_comp_prev_reg <= 1'b0;
        end
        else
        begin
            cpu_comp_prev_reg <= cpu_comp_trip_i;
            gpu_comp_prev_reg <= gpu_comp_trip_i;
        end
    end

    // forced single phase narrows the rotation
    assign cpu_nph_eff = (ctrl_reg[CTRL_SINGLE_BIT] && cpu_nph_reg != 2'd0) ? 2'd1
                                                                             : cpu_nph_reg;

    // even spacing comes from rotating over all active phases
    assign cpu_if.run       = state_reg == ST_RUN && cpu_nph_eff != 2'd0;
    assign cpu_if.act       = state_reg != ST_IDLE && cpu_nph_eff != 2'd0;
    assign cpu_if.trig      = state_reg == ST_RUN && cpu_comp_trip_i && !cpu_comp_prev_reg;
    assign cpu_if.usr_allow = ctrl_reg[CTRL_USR_EN_BIT] && cpu_usr_trip_i;
    // overshoot cut disabled by the strap level
    assign cpu_if.osr_block = cpu_osr_trip_i && !cpu_strap_reg[SF_OSR_OFF];
    assign cpu_if.nph       = cpu_nph_eff;
    // on-time from input and output voltage
    assign cpu_if.ton       = mps_ton_calc(cpu_vout_code_i, vin_code_i,
                                           cpu_strap_reg[SF_FREQ +: 3]);
    assign cpu_if.iph       = cpu_phase_current_i;

    assign gpu_if.run       = state_reg == ST_RUN && gpu_on_reg;
    assign gpu_if.act       = state_reg != ST_IDLE && gpu_on_reg;
    assign gpu_if.trig      = state_reg == ST_RUN && gpu_comp_trip_i && !gpu_comp_prev_reg;
    assign gpu_if.usr_allow = ctrl_reg[CTRL_USR_EN_BIT] && gpu_usr_trip_i;
    assign gpu_if.osr_block = gpu_osr_trip_i && !gpu_strap_reg[SF_OSR_OFF];
    assign gpu_if.nph       = {1'b0, gpu_on_reg};
    assign gpu_if.ton       = mps_ton_calc(gpu_vout_code_i, vin_code_i,
                                           gpu_strap_reg[SF_FREQ +: 3]);
    assign gpu_if.iph       = gpu_phase_current_i;

    // per-phase trim lives in the phase sequencer
    mps_phase_seq #(.NPH(3)) u_cpu_seq
    (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .ch      (cpu_if)
    );

    mps_phase_seq #(.NPH(1)) u_gpu_seq
    (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .ch      (gpu_if)
    );

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cpu_pulse_reg <= 16'h0000;
            gpu_pulse_reg <= 16'h0000;
        end
        else
        begin
            if (cpu_if.launch)
                cpu_pulse_reg <= cpu_pulse_reg + 16'h0001;
            if (gpu_if.launch)
                gpu_pulse_reg <= gpu_pulse_reg + 16'h0001;
        end
    end

    // apb slave, zero wait states
    assign apb_setup = psel_i && !penable_i;
    assign apb_write = psel_i && penable_i && pwrite_i && addr_ok;
    assign addr_ok   = paddr_i == ADDR_CTRL || paddr_i == ADDR_STATUS
                       || paddr_i == ADDR_CPU_STRAP || paddr_i == ADDR_GPU_STRAP
                       || paddr_i == ADDR_SLEW || paddr_i == ADDR_PULSES;

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        unique case (paddr_i)
            ADDR_CTRL:
                rd_mux = {30'h0000_0000, ctrl_reg};
            ADDR_STATUS:
            begin
                rd_mux[ST_F_STATE +: 2] = state_reg;
                rd_mux[ST_F_NPH +: 2]   = cpu_nph_eff;
                rd_mux[ST_F_GPU]        = gpu_on_reg;
                rd_mux[ST_F_OSR]        = cpu_if.osr_block;
                rd_mux[ST_F_OSR + 1]    = gpu_if.osr_block;
            end
            ADDR_CPU_STRAP:
                rd_mux = {16'h0000, cpu_strap_reg};
            ADDR_GPU_STRAP:
                rd_mux = {16'h0000, gpu_strap_reg};
            ADDR_SLEW:
                rd_mux = {16'h0000, slow_voltage_change_rate_o, fast_voltage_change_rate_o};
            ADDR_PULSES:
                rd_mux = {gpu_pulse_reg, cpu_pulse_reg};
            default:
                rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            prdata_reg <= 32'h0000_0000;
        else if (apb_setup)
            prdata_reg <= rd_mux;
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            ctrl_reg <= CTRL_RESET;
        else if (apb_write && paddr_i == ADDR_CTRL)
            ctrl_reg <= pwdata_i[1:0];
    end

    assign prdata_o  = prdata_reg;
    assign pready_o  = 1'b1;
    assign pslverr_o = psel_i && penable_i && !addr_ok;

    assign cpu_high_drive_o = cpu_if.hs;
    assign cpu_low_drive_o  = cpu_if.ls;
    assign gpu_high_drive_o = gpu_if.hs[0];
    assign gpu_low_drive_o  = gpu_if.ls[0];

    // slow rate a quarter of the common fast rate
    assign fast_voltage_change_rate_o = mps_slew_fast(slew_reg);
    assign slow_voltage_change_rate_o = mps_slew_fast(slew_reg) >> 2;
    assign cpu_ocp_level_o    = cpu_strap_reg[SF_OCP +: 3];
    assign gpu_ocp_level_o    = gpu_strap_reg[SF_OCP +: 3];
    assign regulator_active_o = state_reg != ST_IDLE;

    a_strap_hold:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
        state_reg != ST_IDLE && $past(state_reg) != ST_IDLE |->
        $stable(cpu_strap_reg) && $stable(gpu_strap_reg) && $stable(slew_reg))
        else $error("strap changed during operation");

    a_strap_latch:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
        state_reg == ST_IDLE && en_filt_reg |=>
        state_reg == ST_RUN && cpu_strap_reg == $past(cpu_strap_in))
        else $error("strap not latched at enable");

    a_slew_quarter:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
        {slow_voltage_change_rate_o, 2'b00} == {2'b00, fast_voltage_change_rate_o})
        else $error("slow rate not a quarter of fast rate");

    a_stop_no_trig:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !en_filt_reg ##1 !en_filt_reg |-> !cpu_if.trig && !gpu_if.trig)
        else $error("trigger accepted while disabled");

    a_osr_disabled:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
        gpu_strap_reg[SF_OSR_OFF] && gpu_osr_trip_i && gpu_if.act |=>
        gpu_low_drive_o || gpu_high_drive_o)
        else $error("overshoot cut active though disabled");
endmodule
`default_nettype wire

// *** mps_drv_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module mps_drv_model
#(
    parameter int N = 3
)(
    input  wire logic           clk_i,
    input  wire logic           rst_n_i,
    input  wire logic [N-1:0]   hs_i,
    input  wire logic [N-1:0]   ls_i,
    output logic [8*N-1:0]      cur_o
);
    // inductor current ramps up on high side, decays on low side
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            cur_o <= '0;
        else
            for (int p = 0; p < N; p++)
            begin
                if (hs_i[p])
                    cur_o[8*p+:8] <= cur_o[8*p+:8] + 8'h08;
                else if (ls_i[p] && cur_o[8*p+:8] != 8'h00)
                    cur_o[8*p+:8] <= cur_o[8*p+:8] - 8'h01;
            end
    end
endmodule
`default_nettype wire

// *** mps_sequencer_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module mps_sequencer_tb;
    import mps_pkg::*;
    logic        clk_i, rst_n_i, psel, pen, pwr, pready, pslverr, err, en, act, ghs, gls;
    logic        ctrip, cosr, gosr, gtrip;
    logic [7:0]  paddr, vin, cvo, gvo, gcur, fr, sr;
    logic [2:0]  cf, ci, co, cm, gf, gi, go, gm, slew, chs, cls, cocp, gocp, csp, csn, sl;
    logic [3:0]  ct, gt;
    logic [23:0] ccur;
    logic [31:0] pwdata, prdata, rd, rng, sw;
    int          num_errors, n_tests, lf;

    mps_sequencer i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(pen),
        .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .regulator_enable_in_i(en),
        .cpu_freq_limit_strap_i(cf), .cpu_imax_info_i(ci), .cpu_overcurrent_strap_i(co),
        .cpu_monitor_strap_i(cm), .cpu_transient_strap_i(ct), .gpu_freq_limit_strap_i(gf),
        .gpu_imax_info_i(gi), .gpu_overcurrent_strap_i(go), .gpu_monitor_strap_i(gm),
        .gpu_transient_strap_i(gt), .slew_select_strap_i(slew), .cpu_sense_pos_high_i(csp),
        .cpu_sense_neg_low_i(csn), .gpu_sense_pos_high_i(1'b0), .gpu_sense_neg_low_i(1'b0),
        .vin_code_i(vin), .cpu_vout_code_i(cvo), .gpu_vout_code_i(gvo),
        .cpu_comp_trip_i(ctrip), .gpu_comp_trip_i(gtrip), .cpu_usr_trip_i(1'b0),
        .gpu_usr_trip_i(1'b0), .cpu_osr_trip_i(cosr), .gpu_osr_trip_i(gosr),
        .cpu_phase_current_i(ccur), .gpu_phase_current_i(gcur), .cpu_high_drive_o(chs),
        .cpu_low_drive_o(cls), .gpu_high_drive_o(ghs), .gpu_low_drive_o(gls),
        .fast_voltage_change_rate_o(fr), .slow_voltage_change_rate_o(sr),
        .cpu_ocp_level_o(cocp), .gpu_ocp_level_o(gocp), .regulator_active_o(act));
    mps_drv_model #(.N(3)) i_cdrv (.clk_i(clk_i), .rst_n_i(rst_n_i), .hs_i(chs), .ls_i(cls),
        .cur_o(ccur));
    mps_drv_model #(.N(1)) i_gdrv (.clk_i(clk_i), .rst_n_i(rst_n_i), .hs_i(ghs), .ls_i(gls),
        .cur_o(gcur));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        if (num_errors == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    // fast rate expected from the latched slew code
    function automatic logic [7:0] efr(input logic [2:0] s);
        return {1'b0, {1'b0, s} + 4'h1, 3'h0};
    endfunction

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        pen <= 1'b1;
        @(posedge clk_i);
        while (pready !== 1'b1)
            @(posedge clk_i);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic draw();
        rng = xs(rng);
        {cf, ci, co, cm, gf, gi, go, gm, slew} <= rng[26:0];
        vin <= rng[31:24] | 8'h01;
        cvo <= rng[31:24] | 8'h01;
        gvo <= rng[23:16];
        @(posedge clk_i);
    endtask

    task automatic pulse(input logic [2:0] exp);
        int k;
        int w;
        k = 0;
        w = 0;
        ctrip <= 1'b1;
        @(posedge clk_i);
        ctrip <= 1'b0;
        while (chs === 3'h0 && k < 20)
        begin
            @(negedge clk_i);
            k++;
        end
        check({29'h0, chs}, {29'h0, exp});
        while (chs !== 3'h0 && w < 300)
        begin
            @(negedge clk_i);
            w++;
        end
        check({31'h0, w >= 235 - 16 * lf && w <= 245 - 16 * lf}, 32'h1);
        @(posedge clk_i);
    endtask

    task automatic enable();
        en <= 1'b1;
        lf = cf;
        sl = slew;
        sw = {16'h0, ct, cm, co, ci, cf};
        repeat (3) @(posedge clk_i);
    endtask

    always @(negedge clk_i)
        if (rst_n_i === 1'b1)
            check({29'h0, chs & (chs - 3'h1)}, 32'h0);

    initial
    begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    initial
    begin
        repeat (20000) @(posedge clk_i);
        num_errors++;
        print_verdict();
    end

    initial
    begin
        {psel, pen, pwr, paddr, pwdata, en, ctrip, cosr, gosr, gtrip, csp, csn} = '0;
        {cf, ci, co, cm, gf, gi, go, gm, slew, vin, cvo, gvo} = '0;
        ct = 4'h0;
        gt = 4'h8;
        num_errors = 0;
        n_tests = 0;
        rng = 32'h11785e96;
        rst_n_i = 1'b0;
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        apb(1'b0, ADDR_CTRL, 32'h0);
        check(rd, {30'h0, CTRL_RESET});
        apb(1'b0, 8'h18, 32'h0);
        check({31'h0, err}, 32'h1);
        draw();
        // enable only once supplies are up
        enable();
        check({31'h0, act}, 32'h1);
        apb(1'b0, ADDR_STATUS, 32'h0);
        check({29'h0, rd[4:2]}, 32'h7);
        draw();
        apb(1'b0, ADDR_CPU_STRAP, 32'h0);
        check(rd, sw);
        check({29'h0, cocp}, {29'h0, sw[8:6]});
        check({24'h0, fr}, {24'h0, efr(sl)});
        apb(1'b0, ADDR_SLEW, 32'h0);
        check({24'h0, sr}, {24'h0, efr(sl) >> 2});
        check(rd, {16'h0, efr(sl) >> 2, efr(sl)});
        for (int i = 0; i < 4; i++)
            pulse(3'h1 << (i % 3));
        apb(1'b0, ADDR_PULSES, 32'h0);
        check({16'h0, rd[15:0]}, 32'h4);
        en <= 1'b0;
        repeat (6) @(posedge clk_i);
        check({31'h0, act}, 32'h0);
        csp <= 3'h4;
        csn <= 3'h4;
        enable();
        pulse(3'h1);
        apb(1'b0, ADDR_STATUS, 32'h0);
        check({30'h0, rd[3:2]}, 32'h2);
        apb(1'b1, ADDR_CTRL, 32'h3);
        for (int i = 0; i < 3; i++)
            pulse(3'h1);
        cosr <= 1'b1;
        gosr <= 1'b1;
        repeat (3) @(negedge clk_i);
        check({29'h0, cls}, 32'h0);
        check({31'h0, gls}, 32'h1);
        cosr <= 1'b0;
        repeat (3) @(negedge clk_i);
        check({29'h0, cls}, 32'h1);
        gtrip <= 1'b1;
        @(posedge clk_i);
        gtrip <= 1'b0;
        @(negedge clk_i);
        check({31'h0, ghs}, 32'h1);
        print_verdict();
    end
endmodule
`default_nettype wire
